// >>> design/pin_if.sv
`timescale 1ns/100ps
// Raw and synchronised bus pin levels between core and synchroniser
interface pin_if;
	logic scl_raw;
	logic sda_raw;
	logic scl_s;
	logic sda_s;
	modport sync (input scl_raw, input sda_raw, output scl_s, output sda_s);
	modport core (output scl_raw, output sda_raw, input scl_s, input sda_s);
endinterface

// >>> design/pin_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for the clock and data pins
module pin_sync (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	pin_if.sync pins
);
	twi_pkg::sync_t q;
	twi_pkg::sync_t d;

	always_comb begin
		d.meta = {pins.scl_raw, pins.sda_raw};
		d.sync = q.meta;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			q <= '1;
		end else begin
			q <= d;
		end
	end

	assign pins.scl_s = q.sync[1];
	assign pins.sda_s = q.sync[0];
endmodule

// >>> design/twi_cfg.svh
// Register map, field positions, reset values, status codes and timing
`ifndef TWI_CFG_SVH
`define TWI_CFG_SVH
`define TWI_ADR_CTL 8'h93
`define TWI_ADR_STS 8'h94
`define TWI_ADR_DAT 8'h95
`define TWI_ADR_OWN 8'h96
`define TWI_ADR_IST 8'h97
`define TWI_ADR_IMSK 8'h98
`define TWI_CTL_RATE2 7
`define TWI_CTL_EN 6
`define TWI_CTL_START_REQ 5
`define TWI_CTL_STOP_REQ 4
`define TWI_CTL_SI 3
`define TWI_CTL_ACK_ASSERT 2
`define TWI_CTL_RATE1 1
`define TWI_CTL_RATE0 0
`define TWI_OWN_GCEN 0
`define TWI_IST_SRV 0
`define TWI_IST_ERR 1
`define TWI_IST_ARB 2
`define TWI_RST_CTL 8'h00
`define TWI_RST_STS 8'hF8
`define TWI_RST_OWN 8'hFE
`define TWI_SC_BUSERR 8'h00
`define TWI_SC_START 8'h08
`define TWI_SC_RSTART 8'h10
`define TWI_SC_MT_ADDR_ACK 8'h18
`define TWI_SC_MT_ADDR_NACK 8'h20
`define TWI_SC_MT_DAT_ACK 8'h28
`define TWI_SC_MT_DAT_NACK 8'h30
`define TWI_SC_ARB 8'h38
`define TWI_SC_MR_ADDR_ACK 8'h40
`define TWI_SC_MR_ADDR_NACK 8'h48
`define TWI_SC_MR_DAT_ACK 8'h50
`define TWI_SC_MR_DAT_NACK 8'h58
`define TWI_SC_SR_ADDR 8'h60
`define TWI_SC_SR_GCALL 8'h70
`define TWI_SC_SR_DAT_ACK 8'h80
`define TWI_SC_SR_DAT_NACK 8'h88
`define TWI_SC_SR_GC_ACK 8'h90
`define TWI_SC_SR_GC_NACK 8'h98
`define TWI_SC_SR_STOP 8'hA0
`define TWI_SC_ST_ADDR 8'hA8
`define TWI_SC_ST_DAT_ACK 8'hB8
`define TWI_SC_ST_DAT_NACK 8'hC0
`define TWI_SC_ST_LAST_ACK 8'hC8
`define TWI_CLK_NS 10
`define TWI_QTR_NS 625
`endif

// >>> design/twi_pkg.sv
// Types shared by the two-wire register block and its synchroniser
package twi_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_MBYTE,
		ST_WAIT,
		ST_STOP,
		ST_SBYTE
	} st_t;

	typedef struct packed {
		st_t st;
		logic [7:0] ctl;
		logic [7:0] sdat;
		logic [7:0] own;
		logic [7:0] code;
		logic [7:0] rdat;
		logic [7:0] sh;
		logic [2:0] ist;
		logic [2:0] imask;
		logic [1:0] ph;
		logic [3:0] bcnt;
		logic [15:0] div;
		logic mst;
		logic tx;
		logic first;
		logic rw;
		logic gcall;
		logic ackd;
		logic busy;
		logic scl_oe;
		logic sda_oe;
		logic pin_lvl;
		logic prv_scl;
		logic prv_sda;
		logic irq;
	} state_t;

	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
	} sync_t;
endpackage

// >>> design/twi_regs.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
// Two-wire bus controller with its software register set
`include "twi_cfg.svh"
module twi_regs #(
	parameter int QTR_CYC = `TWI_QTR_NS / `TWI_CLK_NS
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rd_data_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic irq_o
);
	twi_pkg::state_t q;
	twi_pkg::state_t d;
	logic scl_s;
	logic sda_s;
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;
	logic tick;
	logic set_si;
	logic ev_err;
	logic ev_arb;
	logic match;
	logic [2:0] rate;
	logic [3:0] nb;
	logic [15:0] reload;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	pin_if pins();
	assign pins.scl_raw = scl_i;
	assign pins.sda_raw = sda_i;
	assign scl_s = pins.scl_s;
	assign sda_s = pins.sda_s;

	pin_sync u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.pins(pins)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus events and rate divider

	assign start_det = q.prv_sda & ~sda_s & scl_s & q.prv_scl;
	assign stop_det = ~q.prv_sda & sda_s & scl_s & q.prv_scl;
	assign scl_rise = scl_s & ~q.prv_scl;
	assign scl_fall = ~scl_s & q.prv_scl;
	assign rate = {q.ctl[`TWI_CTL_RATE2], q.ctl[`TWI_CTL_RATE1],
		q.ctl[`TWI_CTL_RATE0]};
	assign reload = (16'(QTR_CYC) << rate) - 16'h0001;
	assign tick = q.div == 16'h0000;
	assign match = q.ctl[`TWI_CTL_ACK_ASSERT] &
		((q.sh[7:1] == q.own[7:1]) |
		(q.own[`TWI_OWN_GCEN] & (q.sh == 8'h00)));
	assign nb = q.bcnt + 4'h1;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d = q;
		set_si = 1'b0;
		ev_err = 1'b0;
		ev_arb = 1'b0;
		d.rdat = 8'h00;
		d.prv_scl = scl_s;
		d.prv_sda = sda_s;
		if (start_det) begin
			d.busy = 1'b1;
		end else if (stop_det) begin
			d.busy = 1'b0;
		end

		// Register port
		if (wr_i) begin
			case (addr_i)
				`TWI_ADR_CTL: begin
					d.ctl = wr_data_i;
					d.ctl[`TWI_CTL_SI] = wr_data_i[`TWI_CTL_SI] &
						q.ctl[`TWI_CTL_SI];
				end
				`TWI_ADR_DAT: d.sdat = wr_data_i;
				`TWI_ADR_OWN: d.own = wr_data_i;
				`TWI_ADR_IST: d.ist = q.ist & ~wr_data_i[2:0];
				`TWI_ADR_IMSK: d.imask = wr_data_i[2:0];
				default: ;
			endcase
		end
		if (rd_i) begin
			case (addr_i)
				`TWI_ADR_CTL: d.rdat = q.ctl;
				`TWI_ADR_STS: d.rdat = {q.code[7:3], 3'b000};
				`TWI_ADR_DAT: d.rdat = q.sdat;
				`TWI_ADR_OWN: d.rdat = q.own;
				`TWI_ADR_IST: d.rdat = {5'h00, q.ist};
				`TWI_ADR_IMSK: d.rdat = {5'h00, q.imask};
				default: d.rdat = 8'h00;
			endcase
		end

		// Quarter-bit divider runs only in master bus phases
		if (q.st == twi_pkg::ST_START || q.st == twi_pkg::ST_MBYTE ||
			q.st == twi_pkg::ST_STOP) begin
			d.div = tick ? reload : q.div - 16'h0001;
		end else begin
			d.div = reload;
		end

		if (!q.ctl[`TWI_CTL_EN]) begin
			d.st = twi_pkg::ST_IDLE;
			d.scl_oe = 1'b0;
			d.sda_oe = 1'b0;
			d.mst = 1'b0;
		end else begin
			case (q.st)
				twi_pkg::ST_IDLE: begin
					if (q.ctl[`TWI_CTL_START_REQ] && !q.busy &&
						!q.ctl[`TWI_CTL_SI]) begin
						d.st = twi_pkg::ST_START;
						d.ph = 2'd0;
					end else if (start_det &&
						q.ctl[`TWI_CTL_ACK_ASSERT]) begin
						d.st = twi_pkg::ST_SBYTE;
						d.bcnt = 4'hF;
						d.first = 1'b1;
						d.tx = 1'b0;
						d.gcall = 1'b0;
					end
				end
				twi_pkg::ST_START: begin
					if (tick) begin
						case (q.ph)
							2'd0: begin
								d.sda_oe = 1'b0;
								d.ph = 2'd1;
							end
							2'd1: begin
								d.scl_oe = 1'b0;
								d.ph = 2'd2;
							end
							2'd2: begin
								if (scl_s) begin
									d.sda_oe = 1'b1;
									d.ph = 2'd3;
								end
							end
							default: begin
								d.scl_oe = 1'b1;
								d.ph = 2'd0;
								d.code = q.mst ? `TWI_SC_RSTART :
									`TWI_SC_START;
								d.mst = 1'b1;
								d.first = 1'b1;
								d.st = twi_pkg::ST_WAIT;
								set_si = 1'b1;
							end
						endcase
					end
				end
				twi_pkg::ST_MBYTE: begin
					if (start_det || stop_det) begin
						ev_err = 1'b1;
					end else if (tick) begin
						case (q.ph)
							2'd0: begin
								if (q.bcnt < 4'd8) begin
									d.sda_oe = q.tx & ~q.sh[7];
								end else begin
									d.sda_oe = ~q.tx &
										q.ctl[`TWI_CTL_ACK_ASSERT];
								end
								d.ph = 2'd1;
							end
							2'd1: begin
								d.scl_oe = 1'b0;
								d.ph = 2'd2;
							end
							2'd2: begin
								if (scl_s) begin
									d.ph = 2'd3;
									if (q.bcnt == 4'd8) begin
										d.ackd = ~sda_s;
									end else if (q.tx && !q.sda_oe &&
										!sda_s) begin
										ev_arb = 1'b1;
									end else begin
										d.sh = {q.sh[6:0], sda_s};
									end
								end
							end
							default: begin
								d.scl_oe = 1'b1;
								d.ph = 2'd0;
								if (q.bcnt != 4'd8) begin
									d.bcnt = nb;
								end else begin
									d.sda_oe = 1'b0;
									d.st = twi_pkg::ST_WAIT;
									d.first = 1'b0;
									set_si = 1'b1;
									if (q.first) begin
										d.tx = ~q.rw;
										if (q.rw) begin
											d.code = q.ackd ?
												`TWI_SC_MR_ADDR_ACK :
												`TWI_SC_MR_ADDR_NACK;
										end else begin
											d.code = q.ackd ?
												`TWI_SC_MT_ADDR_ACK :
												`TWI_SC_MT_ADDR_NACK;
										end
									end else if (q.tx) begin
										d.code = q.ackd ?
											`TWI_SC_MT_DAT_ACK :
											`TWI_SC_MT_DAT_NACK;
									end else begin
										d.sdat = q.sh;
										d.code = q.ctl[`TWI_CTL_ACK_ASSERT] ?
											`TWI_SC_MR_DAT_ACK :
											`TWI_SC_MR_DAT_NACK;
									end
								end
							end
						endcase
					end
				end
				twi_pkg::ST_WAIT: begin
					d.scl_oe = 1'b1;
					if (!q.ctl[`TWI_CTL_SI]) begin
						d.ph = 2'd0;
						d.bcnt = 4'd0;
						if (q.mst && q.ctl[`TWI_CTL_STOP_REQ]) begin
							d.st = twi_pkg::ST_STOP;
						end else if (q.mst && q.ctl[`TWI_CTL_START_REQ]) begin
							d.st = twi_pkg::ST_START;
						end else begin
							d.sh = q.sdat;
							if (q.first) begin
								d.rw = q.sdat[0];
							end
							if (q.mst) begin
								d.st = twi_pkg::ST_MBYTE;
								d.tx = q.first | q.tx;
							end else begin
								d.st = twi_pkg::ST_SBYTE;
								d.scl_oe = 1'b0;
								d.sda_oe = q.tx & ~q.sdat[7];
							end
						end
					end
				end
				twi_pkg::ST_STOP: begin
					if (tick) begin
						case (q.ph)
							2'd0: begin
								d.sda_oe = 1'b1;
								d.ph = 2'd1;
							end
							2'd1: begin
								d.scl_oe = 1'b0;
								d.ph = 2'd2;
							end
							2'd2: begin
								if (scl_s) begin
									d.sda_oe = 1'b0;
									d.ph = 2'd3;
								end
							end
							default: begin
								d.ph = 2'd0;
								d.ctl[`TWI_CTL_STOP_REQ] = 1'b0;
								d.mst = 1'b0;
								d.code = `TWI_RST_STS;
								d.st = twi_pkg::ST_IDLE;
							end
						endcase
					end
				end
				twi_pkg::ST_SBYTE: begin
					if ((start_det || stop_det) &&
						(q.bcnt == 4'd0 || q.bcnt == 4'hF)) begin
						d.sda_oe = 1'b0;
						if (!q.first) begin
							d.code = `TWI_SC_SR_STOP;
							set_si = 1'b1;
						end
						d.st = start_det && q.ctl[`TWI_CTL_ACK_ASSERT] ?
							twi_pkg::ST_SBYTE : twi_pkg::ST_IDLE;
						d.bcnt = 4'hF;
						d.first = 1'b1;
						d.tx = 1'b0;
					end else if (start_det || stop_det) begin
						ev_err = 1'b1;
					end else if (scl_rise) begin
						if (q.bcnt == 4'd8) begin
							d.ackd = ~sda_s;
						end else if (q.bcnt < 4'd8) begin
							d.sh = {q.sh[6:0], sda_s};
						end
					end else if (scl_fall) begin
						if (q.bcnt != 4'd8) begin
							d.bcnt = nb;
							if (nb < 4'd8) begin
								d.sda_oe = q.tx & ~q.sh[7];
							end else if (q.tx) begin
								d.sda_oe = 1'b0;
							end else if (q.first) begin
								d.sda_oe = match;
								if (!match) begin
									d.st = twi_pkg::ST_IDLE;
								end
							end else begin
								d.sda_oe = q.ctl[`TWI_CTL_ACK_ASSERT];
							end
						end else begin
							d.sda_oe = 1'b0;
							d.scl_oe = 1'b1;
							d.st = twi_pkg::ST_WAIT;
							set_si = 1'b1;
							if (q.first) begin
								d.first = 1'b0;
								d.gcall = q.sh == 8'h00;
								d.tx = q.sh[0] & (q.sh != 8'h00);
								if (q.sh == 8'h00) begin
									d.code = `TWI_SC_SR_GCALL;
								end else begin
									d.code = q.sh[0] ? `TWI_SC_ST_ADDR :
										`TWI_SC_SR_ADDR;
								end
							end else if (q.tx) begin
								if (!q.ackd) begin
									d.code = `TWI_SC_ST_DAT_NACK;
								end else begin
									d.code = q.ctl[`TWI_CTL_ACK_ASSERT] ?
										`TWI_SC_ST_DAT_ACK :
										`TWI_SC_ST_LAST_ACK;
								end
								if (!q.ackd ||
									!q.ctl[`TWI_CTL_ACK_ASSERT]) begin
									d.scl_oe = 1'b0;
									d.st = twi_pkg::ST_IDLE;
								end
							end else begin
								d.sdat = q.sh;
								if (q.gcall) begin
									d.code = q.ctl[`TWI_CTL_ACK_ASSERT] ?
										`TWI_SC_SR_GC_ACK :
										`TWI_SC_SR_GC_NACK;
								end else begin
									d.code = q.ctl[`TWI_CTL_ACK_ASSERT] ?
										`TWI_SC_SR_DAT_ACK :
										`TWI_SC_SR_DAT_NACK;
								end
							end
						end
					end
				end
				default: d.st = twi_pkg::ST_IDLE;
			endcase
			if (ev_err || ev_arb) begin
				d.scl_oe = 1'b0;
				d.sda_oe = 1'b0;
				d.mst = 1'b0;
				d.st = twi_pkg::ST_IDLE;
				d.ph = 2'd0;
				d.code = ev_err ? `TWI_SC_BUSERR : `TWI_SC_ARB;
				set_si = 1'b1;
			end
			if (ev_err) begin
				d.ctl[`TWI_CTL_STOP_REQ] = 1'b0;
			end
		end

		// Hardware set wins over a simultaneous software clear
		if (set_si) begin
			d.ctl[`TWI_CTL_SI] = 1'b1;
		end
		d.ist = d.ist | {ev_arb, ev_err, set_si};
		d.irq = |(d.ist & d.imask);
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			q <= '0;
			q.ctl <= `TWI_RST_CTL;
			q.code <= `TWI_RST_STS;
			q.own <= `TWI_RST_OWN;
			q.prv_scl <= 1'b1;
			q.prv_sda <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign rd_data_o = q.rdat;
	assign scl_o = q.pin_lvl;
	assign scl_oe_o = q.scl_oe;
	assign sda_o = q.pin_lvl;
	assign sda_oe_o = q.sda_oe;
	assign irq_o = q.irq;
endmodule

// >>> test/twi_regs_properties.sv
// Port-level checks of the two-wire register block
`timescale 1ns/100ps
module twi_regs_properties #(
	parameter int QTR_CYC = 62
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rd_data_o,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe_o,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic irq_o
);
	logic en_q;
	logic start_q;
	logic stop_q;
	logic ctl_wr;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	assign ctl_wr = wr_i && addr_i == 8'h93;
	// Last written enable, start and stop bits
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			en_q <= 1'b0;
			start_q <= 1'b0;
			stop_q <= 1'b0;
		end else if (ctl_wr) begin
			en_q <= wr_data_i[6];
			start_q <= wr_data_i[5];
			stop_q <= wr_data_i[4];
		end
	end
	////////////////////////////////////////////////////////////////////////
	sts_low_a: assert property (rd_i && addr_i == 8'h94 |=>
		rd_data_o[2:0] == 3'h0) else $error("status low bits not zero");
	own_rb_a: assert property (wr_i && addr_i == 8'h96 ##1
		rd_i && addr_i == 8'h96 |=> rd_data_o == $past(wr_data_i, 2))
		else $error("own address readback wrong");
	dat_rb_a: assert property (wr_i && addr_i == 8'h95 ##1
		rd_i && addr_i == 8'h95 |=> rd_data_o == $past(wr_data_i, 2))
		else $error("data readback wrong");
	ctl_rb_a: assert property (ctl_wr ##1 rd_i && addr_i == 8'h93 |=>
		(rd_data_o & 8'hC3) == ($past(wr_data_i, 2) & 8'hC3))
		else $error("rate or enable readback wrong");
	off_quiet_a: assert property (!en_q && !$past(en_q) |->
		!scl_oe_o && !sda_oe_o) else $error("pins driven while off");
	start_req_a: assert property (scl_i && $past(scl_i) &&
		$fell(sda_i) |-> start_q) else $error("start without request");
	stop_req_a: assert property (scl_i && $past(scl_i) &&
		$rose(sda_i) |-> stop_q) else $error("stop without request");
	irq_hold_a: assert property (irq_o && !wr_i && !$past(wr_i)
		|=> irq_o) else $error("interrupt dropped by itself");
endmodule
bind twi_regs twi_regs_properties #(.QTR_CYC(QTR_CYC)) u_twi_regs_properties (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
	.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
	.scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));

// >>> test/twi_regs_tb_top.sv
// Self-checking bench for the two-wire register block
`timescale 1ns/100ps
module twi_regs_tb_top;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wr_data_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic ack_en = 1'b1;
	logic [7:0] rd_data_o;
	logic [7:0] rx_byte;
	logic scl_oe_o;
	logic sda_oe_o;
	logic irq_o;
	logic pull;
	logic scl;
	logic sda;
	int comparisons = 0;
	int miscompares = 0;
	int cycles = 0;
	logic [7:0] rst_val [7] = '{8'h00, 8'hF8, 8'h00, 8'hFE, 8'h00, 8'h00,
		8'h00};
	assign scl = !scl_oe_o;
	assign sda = !(sda_oe_o || pull);
	always #5 clk_i = !clk_i;
	twi_regs #(.QTR_CYC(3)) u_twi_regs (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
		.rd_data_o(rd_data_o), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe_o),
		.sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
	twi_slave_model u_twi_slave_model (
		.scl_i(scl), .sda_i(sda), .ack_en_i(ack_en), .sda_pull_o(pull),
		.rx_byte_o(rx_byte));
	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string n, input logic [7:0] s,
		input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wr_i <= 1'b1;
		rd_i <= 1'b0;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		rd_i <= 1'b1;
		wr_i <= 1'b0;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		q = rd_data_o;
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e,
		input string n);
		logic [7:0] q;
		rd(a, q);
		check(n, q, e);
	endtask
	task automatic wait_irq(input string n);
		wr_i <= 1'b0;
		for (int i = 0; i < 2000 && irq_o !== 1'b1; i++)
			@(posedge clk_i);
		check(n, {7'h00, irq_o}, 8'h01);
	endtask
	// Cycle ceiling
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 8000) begin
			miscompares++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] q;
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 7; i++)
			rdc(8'h93 + 8'(i), rst_val[i], "reset");
		wr(8'h94, 8'h55);
		rdc(8'h94, 8'hF8, "status");
		wr(8'h96, 8'hA5);
		rdc(8'h96, 8'hA5, "own");
		wr(8'h95, 8'h3C);
		rdc(8'h95, 8'h3C, "data");
		for (int i = 0; i < 8; i++) begin
			wr(8'h93, {i[2], 4'h1, 1'b0, i[1:0]});
			rdc(8'h93, {i[2], 5'h00, i[1:0]}, "ctl");
		end
		$display("done registers");
		wr(8'h98, 8'h07);
		wr(8'h93, 8'h60);
		wait_irq("start irq");
		rdc(8'h94, 8'h08, "start code");
		rdc(8'h93, 8'h68, "flag set");
		wr(8'h95, 8'hA4);
		wr(8'h97, 8'h01);
		wr(8'h93, 8'h40);
		wait_irq("addr irq");
		check("rx addr", rx_byte, 8'hA4);
		rdc(8'h94, 8'h18, "addr ack");
		rdc(8'h93, 8'h48, "flag held");
		wr(8'h98, 8'h00);
		rdc(8'h97, 8'h01, "irq status");
		check("masked", {7'h00, irq_o}, 8'h00);
		wr(8'h98, 8'h07);
		ack_en <= 1'b0;
		wr(8'h95, 8'h3C);
		wr(8'h97, 8'h01);
		wr(8'h93, 8'h44);
		wait_irq("data irq");
		check("rx data", rx_byte, 8'h3C);
		rdc(8'h94, 8'h30, "data nack");
		$display("done master write");
		wr(8'h97, 8'h01);
		wr(8'h93, 8'h50);
		for (int i = 0; i < 200; i++) begin
			rd(8'h93, q);
			if (q[4] === 1'b0)
				break;
		end
		check("stop bit", q & 8'h10, 8'h00);
		rdc(8'h94, 8'hF8, "idle code");
		check("bus idle", {6'h00, scl, sda}, 8'h03);
		check("irq low", {7'h00, irq_o}, 8'h00);
		$display("done stop");
		wr(8'h93, 8'h20);
		wr_i <= 1'b0;
		repeat (200) @(posedge clk_i);
		check("off bus", {6'h00, scl, sda}, 8'h03);
		rdc(8'h94, 8'hF8, "off code");
		rdc(8'h93, 8'h20, "off ctl");
		$display("done disable");
		summarize();
	end
endmodule

// >>> test/twi_slave_model.sv
// Behavioural two-wire slave receiver on the far side of the bus
`timescale 1ns/100ps
module twi_slave_model (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic ack_en_i,
	output logic sda_pull_o,
	output logic [7:0] rx_byte_o
);
	int bits = 0;
	initial sda_pull_o = 1'b0;
	initial rx_byte_o = 8'h00;
	// Start restarts the bit count
	always @(negedge sda_i)
		if (scl_i)
			bits = 0;
	always @(posedge scl_i) begin
		if (bits < 8)
			rx_byte_o = {rx_byte_o[6:0], sda_i};
		bits = bits + 1;
	end
	// Ninth clock is the acknowledge slot
	always @(negedge scl_i) begin
		if (bits == 9)
			bits = 0;
		sda_pull_o = bits == 8 && ack_en_i;
	end
endmodule
